// ===== rtl/pcmp_port.sv
// pcm audio master port: bit clock, frame sync, full-duplex word shifter
`timescale 1ns/1ps
`include "pcmp_consts.svh"

module pcmp_port #(
  parameter int DIV        = `PCMP_DIV,
  parameter int FRAME_BITS = `PCMP_FRAME_BITS
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  // link pins
  input  wire logic              pcmDataIn,
  output pcmp_pkg::pcmp_pins_s   pcmPins
);
  import pcmp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (DIV < 4 || DIV > 255 || (DIV % 2) != 0) begin : gBadDiv
      $error("pcmp_port: DIV must be even and within 4..255");
    end
    if (FRAME_BITS < 18 || FRAME_BITS > 255) begin : gBadFrame
      $error("pcmp_port: FRAME_BITS must be within 18..255");
    end
  endgenerate

  localparam logic [7:0] LastPhase = 8'(DIV - 1);
  localparam logic [7:0] HalfPhase = 8'(DIV / 2);
  localparam logic [7:0] LastBit   = 8'(FRAME_BITS - 1);
  localparam logic [7:0] SyncBits  = 8'(`PCMP_SYNC_BITS);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  pcmp_cfg_s   ctrl_q;
  pcmp_cfg_s   cfgRun_q;
  logic [15:0] txData_q;
  logic [15:0] rxData_q;
  logic        rxRdy_q;
  logic        ovr_q;
  logic        txEmpty_q;
  logic [7:0]  phase_q;
  logic [7:0]  bitCnt_q;
  logic [15:0] txSh_q;
  logic [15:0] rxSh_q;
  logic        rxHave_q;
  logic        dinMeta_q;
  logic        dinSync_q;

  logic        wrCtrl;
  logic        wrTx;
  logic        wrSt;
  logic        rdRx;
  logic        riseTick;
  logic        fallTick;
  logic        frameStart;
  logic        launchTick;
  logic        sampleTick;
  logic [7:0]  wordLen;
  logic [7:0]  txBit;
  logic [7:0]  rxBit;
  logic [3:0]  txIdx;
  logic [3:0]  rxIdx;
  logic        txSlot;
  logic        rxSlot;
  logic        rxDone;

  assign wrCtrl = regWr && regAddr == `PCMP_OFS_CTRL;
  assign wrTx   = regWr && regAddr == `PCMP_OFS_TXDATA;
  assign wrSt   = regWr && regAddr == `PCMP_OFS_STATUS;
  assign rdRx   = regRd && regAddr == `PCMP_OFS_RXDATA;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q   <= `PCMP_RST_CTRL;
      txData_q <= `PCMP_RST_TXDATA;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= regWdata[3:0];
      end
      if (wrTx) begin
        txData_q <= regWdata[15:0];
      end
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      unique case (regAddr)
        `PCMP_OFS_CTRL:   regRdata <= {28'h0, ctrl_q};
        `PCMP_OFS_TXDATA: regRdata <= {16'h0, txData_q};
        `PCMP_OFS_RXDATA: regRdata <= {16'h0, rxData_q};
        `PCMP_OFS_STATUS: regRdata <= {28'h0, cfgRun_q.enable, txEmpty_q,
                                       ovr_q, rxRdy_q};
        default:          regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // data-in synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end else begin
      dinMeta_q <= pcmDataIn;
      dinSync_q <= dinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // bit clock and frame timing
  // ----------------------------------------------------------------
  // divider to 1 MHz
  always_ff @(posedge mclk) begin
    if (srst || !ctrl_q.enable) begin
      phase_q  <= 8'h0;
      bitCnt_q <= 8'h0;
    end else if (phase_q == LastPhase) begin
      phase_q  <= 8'h0;
      bitCnt_q <= (bitCnt_q == LastBit) ? 8'h0 : bitCnt_q + 8'h1;
    end else begin
      phase_q <= phase_q + 8'h1;
    end
  end

  assign riseTick   = ctrl_q.enable && phase_q == 8'h0;
  assign fallTick   = ctrl_q.enable && phase_q == HalfPhase;
  assign frameStart = riseTick && bitCnt_q == 8'h0;

  always_ff @(posedge mclk) begin
    if (srst || !ctrl_q.enable) begin
      pcmPins.bitClk    <= 1'b0;
      pcmPins.frameSync <= 1'b0;
    end else if (riseTick) begin
      pcmPins.bitClk <= 1'b1;
      pcmPins.frameSync <= bitCnt_q < SyncBits;
    end else if (fallTick) begin
      pcmPins.bitClk <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // word shifting
  // ----------------------------------------------------------------
  // settings only change at a frame boundary, or when enable clears, so a word is never split by a mode change
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfgRun_q <= `PCMP_RST_CTRL;
      txSh_q   <= 16'h0;
    end else if (!ctrl_q.enable) begin
      cfgRun_q <= `PCMP_RST_CTRL;
    end else if (frameStart) begin
      cfgRun_q <= ctrl_q;
      txSh_q   <= txData_q;
    end
  end

  assign wordLen = cfgRun_q.word16 ? 8'd16 : 8'd8;
  assign launchTick = cfgRun_q.fallSample ? riseTick : fallTick;
  assign sampleTick = cfgRun_q.fallSample ? fallTick : riseTick;
  assign txBit  = bitCnt_q - SyncBits;
  assign txSlot = bitCnt_q >= SyncBits && txBit < wordLen;
  // rising-edge sampling sees each bit one bit clock later
  assign rxBit  = cfgRun_q.fallSample ? txBit : txBit - 8'h1;
  assign rxSlot = bitCnt_q >= SyncBits + (cfgRun_q.fallSample ? 8'h0 : 8'h1)
                  && rxBit < wordLen;
  assign txIdx  = cfgRun_q.lsbFirst ? txBit[3:0] : 4'(wordLen - 8'h1 - txBit);
  assign rxIdx  = cfgRun_q.lsbFirst ? rxBit[3:0] : 4'(wordLen - 8'h1 - rxBit);
  assign rxDone = sampleTick && rxSlot && rxBit == wordLen - 8'h1;

  // one word out per frame
  // data drops with the clock when enable clears, not a cycle later
  always_ff @(posedge mclk) begin
    if (srst || !ctrl_q.enable || !cfgRun_q.enable) begin
      pcmPins.dataOut <= 1'b0;
    end else if (launchTick) begin
      pcmPins.dataOut <= txSlot ? txSh_q[txIdx] : 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxSh_q   <= 16'h0;
      rxHave_q <= 1'b0;
    end else begin
      if (frameStart) begin
        rxSh_q <= 16'h0;
      end else if (sampleTick && rxSlot && cfgRun_q.enable) begin
        rxSh_q[rxIdx] <= dinSync_q;
      end
      if (frameStart || !ctrl_q.enable) begin
        rxHave_q <= 1'b0;
      end else if (rxDone && cfgRun_q.enable) begin
        rxHave_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxData_q  <= 16'h0;
      rxRdy_q   <= 1'b0;
      ovr_q     <= 1'b0;
      txEmpty_q <= 1'b1;
    end else begin
      if (frameStart && rxHave_q) begin
        rxData_q <= rxSh_q;
        rxRdy_q  <= 1'b1;
      end else if (rdRx) begin
        rxRdy_q <= 1'b0;
      end
      if (frameStart && rxHave_q && rxRdy_q && !rdRx) begin
        ovr_q <= 1'b1;
      end else if (wrSt && regWdata[`PCMP_ST_OVR]) begin
        ovr_q <= 1'b0;
      end
      if (frameStart) begin
        txEmpty_q <= 1'b1;
      end else if (wrTx) begin
        txEmpty_q <= 1'b0;
      end
    end
  end

endmodule // pcmp_port

// ===== pkg/pcmp_consts.svh
// constants of the pcm audio master port: offsets, fields, resets, timing
`ifndef PCMP_CONSTS_SVH
`define PCMP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PCMP_OFS_CTRL    4'h0
`define PCMP_OFS_TXDATA  4'h4
`define PCMP_OFS_RXDATA  4'h8
`define PCMP_OFS_STATUS  4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCMP_CTRL_EN      0
`define PCMP_CTRL_W16     1
`define PCMP_CTRL_LSB     2
`define PCMP_CTRL_FALL    3
`define PCMP_ST_RXRDY     0
`define PCMP_ST_OVR       1
`define PCMP_ST_TXEMPTY   2
`define PCMP_ST_RUN       3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCMP_RST_CTRL    4'h0
`define PCMP_RST_TXDATA  16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCMP_MCLK_HZ     50000000
`define PCMP_BCLK_HZ     1000000
`define PCMP_FRAME_US    125
`define PCMP_SYNC_US     1
`define PCMP_DIV         (`PCMP_MCLK_HZ / `PCMP_BCLK_HZ)
`define PCMP_FRAME_BITS  (`PCMP_FRAME_US * (`PCMP_BCLK_HZ / 1000000))
`define PCMP_SYNC_BITS   (`PCMP_SYNC_US * (`PCMP_BCLK_HZ / 1000000))

`endif

// ===== pkg/pcmp_pkg.sv
// types of the pcm audio master port
package pcmp_pkg;

  typedef struct packed {
    logic fallSample;
    logic lsbFirst;
    logic word16;
    logic enable;
  } pcmp_cfg_s;

  typedef struct packed {
    logic bitClk;
    logic frameSync;
    logic dataOut;
  } pcmp_pins_s;

endpackage

// ===== tb/pcmp_port_checker.sv
// assertions on the ports of the pcm audio master port
`timescale 1ns/1ps
module pcmp_port_checker #(
  parameter int DIV        = 50,
  parameter int FRAME_BITS = 125
) (
  // watched ports
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire logic [3:0]           regAddr,
  input wire logic [31:0]          regWdata,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdata,
  input wire logic                 pcmDataIn,
  input wire pcmp_pkg::pcmp_pins_s pcmPins
);
  import pcmp_pkg::*;
  localparam int FR = DIV * FRAME_BITS;
  int hiCnt;
  int perCnt;
  int clkCnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // period and clock counters saturate so a stopped port disarms the timing checks
  always_ff @(posedge mclk) begin
    if (srst || !pcmPins.frameSync) hiCnt <= 0;
    else hiCnt <= hiCnt + 1;
  end
  always_ff @(posedge mclk) begin
    if (srst) perCnt <= 9999;
    else if ($rose(pcmPins.frameSync)) perCnt <= 0;
    else if (perCnt < 9999) perCnt <= perCnt + 1;
  end
  always_ff @(posedge mclk) begin
    if (srst) clkCnt <= 9999;
    else if ($changed(pcmPins.bitClk)) clkCnt <= 1;
    else if (clkCnt < 9999) clkCnt <= clkCnt + 1;
  end
  AST_RST: assert property (disable iff (1'b0) srst |=>
    pcmPins == 3'h0 && regRdata == 32'h0) else $error("not idle in reset");
  AST_RDZERO: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");
  AST_SYNCEDGE: assert property ($rose(pcmPins.frameSync) |->
    $rose(pcmPins.bitClk)) else $error("sync not on clock rise");
  AST_SYNCHI: assert property (hiCnt <= DIV)
    else $error("sync high too long");
  AST_PERIOD: assert property ($rose(pcmPins.frameSync) && perCnt <= FR
    |-> perCnt == FR - 1) else $error("frame period wrong");
  AST_CLKHI: assert property (pcmPins.bitClk && !$changed(pcmPins.bitClk)
    |-> clkCnt < DIV / 2)
    else $error("bit clock high too long");
  AST_CLKLO: assert property ($rose(pcmPins.bitClk) && clkCnt < FR
    |-> clkCnt == DIV / 2) else $error("bit clock low time wrong");
  AST_DEDGE: assert property ($changed(pcmPins.dataOut) |->
    $changed(pcmPins.bitClk)) else $error("data moved off clock edge");
  AST_IDLE: assert property (pcmPins.frameSync |-> !pcmPins.dataOut)
    else $error("data in sync slot");
endmodule // pcmp_port_checker

// ===== tb/pcmp_codec_model.sv
// slave codec model at the far side of the pcm port
`timescale 1ns/1ps
module pcmp_codec_model (
  // link pins
  input wire logic        bitClk,
  input wire logic        frameSync,
  input wire logic        dataOut,
  output logic            dataIn,
  // mode and words
  input wire logic        w16,
  input wire logic        lsb,
  input wire logic        fall,
  input wire logic [15:0] txWord,
  output logic [15:0]     rxWord
);
  int          slot = 99;
  int          n;
  logic [15:0] shift = 16'h0;
  assign n = w16 ? 16 : 8;
  function automatic int pos(input int i);
    return lsb ? i : n - 1 - i;
  endfunction
  // launch opposite edge, junk outside slots
  task automatic launch(input int s);
    if (s >= 1 && s <= n) dataIn = txWord[pos(s - 1)];
    else dataIn = ~dataIn;
  endtask
  initial dataIn = 1'b0;
  initial rxWord = 16'h0;
  // slots counted from the sync, read mid-bit
  always @(negedge bitClk) begin
    slot = frameSync ? 0 : slot + 1;
    if (slot == 0) begin
      rxWord = shift;
      shift = 16'h0;
    end
    if (fall && slot >= 1 && slot <= n) shift[pos(slot - 1)] = dataOut;
    if (!fall) launch(slot);
  end
  always @(posedge bitClk) begin
    if (!fall && slot >= 1 && slot <= n) shift[pos(slot - 1)] = dataOut;
    if (fall) launch(slot + 1);
  end
endmodule // pcmp_codec_model

// ===== tb/pcmp_port_tb.sv
// self-checking bench of the pcm audio master port
`timescale 1ns/1ps
`include "pcmp_consts.svh"
module pcmp_port_tb;
  import pcmp_pkg::*;
  typedef struct packed {
    logic [3:0]  cfg;
    logic [15:0] tx;
    logic [15:0] cw;
  } pcmp_row_s;
  // --------------------------------------------
  // rows: control, word sent, word from codec
  // --------------------------------------------
  pcmp_row_s rows [5] = '{
    '{4'h1, 16'h12a5, 16'h003c}, '{4'h3, 16'h1234, 16'hbeef},
    '{4'h5, 16'h0081, 16'hff17}, '{4'hf, 16'hc3a0, 16'h5a69},
    '{4'h9, 16'h004e, 16'h00d2}};
  logic        mclk, srst, regWr, regRd, pcmDataIn, w16, lsb, fall;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] cWord, cRx, m;
  pcmp_pins_s  pcmPins;
  int          err_count, compares, cyc;
  pcmp_port #(.DIV(8), .FRAME_BITS(20)) uut (.mclk(mclk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pcmDataIn(pcmDataIn), .pcmPins(pcmPins));
  pcmp_codec_model codec (.bitClk(pcmPins.bitClk),
    .frameSync(pcmPins.frameSync), .dataOut(pcmPins.dataOut),
    .dataIn(pcmDataIn), .w16(w16), .lsb(lsb), .fall(fall),
    .txWord(cWord), .rxWord(cRx));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run is near 4000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    d = regRdata;
    compares++;
    if (d !== e) begin
      err_count++;
      $display("Error %0t read %h got %h exp %h", $time, a, d, e);
    end
  endtask
  task automatic chkWord(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t codec got %h exp %h", $time, g, e);
    end
  endtask
  task automatic syncs(input int k);
    repeat (k) @(posedge pcmPins.frameSync);
    repeat (10) @(posedge mclk);
  endtask
  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    {fall, lsb, w16} = 3'h0;
    cWord = 16'h0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      {fall, lsb, w16} <= rows[i].cfg[3:1];
      cWord <= rows[i].cw;
      m = rows[i].cfg[1] ? 16'hffff : 16'h00ff;
      wr(`PCMP_OFS_TXDATA, {16'h0, rows[i].tx});
      wr(`PCMP_OFS_CTRL, {28'h0, rows[i].cfg});
      syncs(3);
      rdChk(`PCMP_OFS_RXDATA, {16'h0, rows[i].cw & m});
      chkWord(cRx, rows[i].tx & m);
      // stop in the sync slot, where the data line is idle
      @(posedge pcmPins.frameSync);
      wr(`PCMP_OFS_CTRL, 32'h0);
      repeat (200) @(posedge mclk);
    end
    {fall, lsb, w16} <= 3'h0;
    wr(`PCMP_OFS_CTRL, 32'h1);
    syncs(4);
    rdChk(`PCMP_OFS_STATUS, 32'hf);
    wr(`PCMP_OFS_STATUS, 32'h2);
    wr(`PCMP_OFS_TXDATA, 32'h5);
    rdChk(`PCMP_OFS_RXDATA, 32'hd2);
    rdChk(`PCMP_OFS_STATUS, 32'h8);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rdChk(`PCMP_OFS_CTRL, 32'h0);
    rdChk(`PCMP_OFS_TXDATA, 32'h0);
    rdChk(`PCMP_OFS_STATUS, 32'h4);
    rdChk(4'h2, 32'h0);
    complete_run();
  end
endmodule // pcmp_port_tb
bind pcmp_port pcmp_port_checker #(.DIV(DIV), .FRAME_BITS(FRAME_BITS)) chk (
  .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .pcmDataIn(pcmDataIn), .pcmPins(pcmPins));
